// *** logic/irq_ctrl_pkg.sv ***
// Shared constants, types and helpers of the nested interrupt controller.
package irq_ctrl_pkg;

    localparam int NUM_VEC = 14;

    // Register indices; the byte address on the bus is four times the index.
    localparam logic [5:0] IDX_PRIO0 = 6'h24;
    localparam logic [5:0] IDX_PRIO1 = 6'h25;
    localparam logic [5:0] IDX_PRIO2 = 6'h26;
    localparam logic [5:0] IDX_PRIO3 = 6'h27;
    localparam logic [5:0] IDX_CTRL = 6'h20;
    localparam logic [5:0] IDX_ENABLE = 6'h21;
    localparam logic [5:0] IDX_PENDING = 6'h22;
    localparam logic [5:0] IDX_COND = 6'h23;

    localparam logic [7:0] PRIO_RESET = 8'hFF;
    localparam logic [7:0] PRIO3_RO_MASK = 8'hF0;
    localparam logic [7:0] COND_RESET = 8'hEA;
    localparam logic [13:0] ENABLE_RESET = 14'h3FFF;

    // Condition-code field positions.
    localparam int LVL_HI_POS = 5;
    localparam int LVL_LO_POS = 3;

    // Ctrl register fields.
    localparam int CTRL_NESTED_POS = 0;
    localparam int CTRL_SPI_SLAVE_POS = 1;

    // Level codes.
    localparam logic [1:0] LVL_MAIN = 2'b10;
    localparam logic [1:0] LVL_ONE = 2'b01;
    localparam logic [1:0] LVL_TWO = 2'b00;
    localparam logic [1:0] LVL_DISABLE = 2'b11;

    localparam logic [15:0] VEC_RESET_ADDR = 16'hFFFE;
    localparam logic [15:0] VEC_TRAP_ADDR = 16'hFFFC;
    localparam logic [15:0] VEC_BASE_ADDR = 16'hFFFA;

    typedef enum logic [2:0] {
        OP_NONE, OP_RIM, OP_SIM, OP_HALT, OP_WFI, OP_RETURN_FROM_IRQ_INSTR, OP_POPCC, OP_TRAP
    } instr_e;

    typedef enum logic [2:0] {
        PWR_RUN, PWR_WAIT, PWR_HALT, PWR_ACTIVE_HALT, PWR_AWU_HALT
    } pwr_e;

    // Ranks a level code so that a larger rank means higher priority.
    // RULE8 level code ranking
    function automatic logic [1:0] level_rank(input logic [1:0] code);
        case (code)
            LVL_MAIN: level_rank = 2'd0;
            LVL_ONE: level_rank = 2'd1;
            LVL_TWO: level_rank = 2'd2;
            default: level_rank = 2'd3;
        endcase
    endfunction

endpackage

// *** logic/wake_filter.sv ***
// Decides which vectors may wake the core in the present power state.
module wake_filter
    import irq_ctrl_pkg::*;
(
    input wire pwr_e pwr_state_i,       // Present power state.
    input wire logic spi_slave_i,       // Serial peripheral works as slave.
    output logic [13:0] wake_mask_o     // One bit per wake-capable vector.
);

    always_comb begin
        wake_mask_o = '0;
        case (pwr_state_i)
            PWR_HALT, PWR_ACTIVE_HALT, PWR_AWU_HALT: begin
                // RULE19 halt wake sources
                wake_mask_o[5:2] = 4'hF;
                wake_mask_o[0] = (pwr_state_i == PWR_AWU_HALT);
                wake_mask_o[1] = (pwr_state_i == PWR_ACTIVE_HALT);
                // RULE20 slave-only wake
                wake_mask_o[8] = spi_slave_i;
                // RULE21 non-waking vectors stay zero
            end
            default: begin
                wake_mask_o = '1;
            end
        endcase
    end

endmodule

// *** logic/prio_arbiter.sv ***
// Picks the eligible vector with highest level, then lowest number.
module prio_arbiter
    import irq_ctrl_pkg::*;
(
    input wire logic [13:0] eligible_i,   // Vectors allowed to compete.
    input wire logic [27:0] prio_i,       // Level code pairs, pair x for vector x.
    output logic found_o,                 // Some vector is eligible.
    output logic [3:0] winner_o           // Number of the winning vector.
);

    logic [1:0] best_rank;
    logic [1:0] cur_rank;

    always_comb begin
        found_o = 1'b0;
        winner_o = 4'd0;
        best_rank = 2'd0;
        cur_rank = 2'd0;
        // RULE22 level first then order
        for (int i = NUM_VEC - 1; i >= 0; i--) begin
            cur_rank = level_rank(prio_i[2*i +: 2]);
            // RULE5 lower number wins ties
            if (eligible_i[i] && (!found_o || cur_rank >= best_rank)) begin
                found_o = 1'b1;
                best_rank = cur_rank;
                winner_o = 4'(i);
            end
        end
    end

endmodule

// *** logic/nested_irq_ctrl.sv ***
// Nested interrupt controller with Wishbone register access.
// Function
// RULE1: Any request wakes the core from Wait.
// RULE2: First service after Halt must be wake-capable.
// RULE3: Non-waking winner follows right after that one.
// RULE4: Concurrent mode never preempts; nested mode does.
// RULE5: Reset, trap, then vectors 0 to 13.
// RULE6: No stack overflow detection or notification.
// RULE7: Level held in condition code bits 5,3.
// RULE8: Codes 10,01,00,11 mean levels 0 to 3.
// RULE9: Reset and trap accepted at level 3.
// RULE10: Entry loads level from vector's programmed priority.
// RULE11: Enable, halt, wait load 10; disable, trap 11.
// RULE12: Branch flags on level equal or unequal 11.
// RULE13: Level instructions change level until next one.
// RULE14: Four priority registers reset FFh, top nibble ones.
// RULE15: Pair x serves vector x; addresses step down.
// RULE16: Writing code 10 into a pair is ignored.
// RULE17: Reset and trap set both level bits.
// RULE18: Raised priority while running re-enters pending vector.
// RULE19: Pins wake Halt; timebase, auto-wakeup in own states.
// RULE20: Serial peripheral wakes Halt only as slave.
// RULE21: Other peripheral vectors never wake from Halt.
// RULE22: Highest level served first, ties by order.
// RULE23: Served only if enabled and above current level.
// RULE24: Entry at instruction end, then vector fetch.
// RULE25: Return restores saved condition code and level.
module nested_irq_ctrl (
    input wire logic clk_i,                          // Core clock.
    input wire logic rst_i,                          // Synchronous reset, high.
    input wire logic cyc_i,                          // Wishbone cycle.
    input wire logic stb_i,                          // Wishbone strobe.
    input wire logic we_i,                           // Wishbone write.
    input wire logic [7:0] adr_i,                    // Wishbone byte address.
    input wire logic [3:0] sel_i,                    // Wishbone byte selects.
    input wire logic [31:0] dat_i,                   // Wishbone write data.
    output logic [31:0] dat_o,                       // Wishbone read data.
    output logic ack_o,                              // Wishbone acknowledge.
    input wire logic [13:0] irq_req_i,               // Request pulses or levels per vector.
    input wire logic instr_valid_i,                  // Core executes instr_op_i now.
    input wire irq_ctrl_pkg::instr_e instr_op_i,     // Level-affecting instruction.
    input wire logic [7:0] stack_cc_i,               // Condition code popped from stack.
    input wire logic boundary_i,                     // Core is at an instruction end.
    input wire irq_ctrl_pkg::pwr_e pwr_state_i,      // Present power state.
    output logic take_o,                             // Pulse: enter a service routine.
    output logic take_trap_o,                        // Entry is the software trap.
    output logic [3:0] take_vector_o,                // Vector number being entered.
    output logic [15:0] vector_addr_o,               // Low byte address of the vector.
    output logic [7:0] cc_o,                         // Condition code register.
    output logic wake_o,                             // Wake the core from low power.
    output logic branch_masked_o,                    // Level is 3.
    output logic branch_unmasked_o                   // Level is not 3.
);
    import irq_ctrl_pkg::*;

    logic [7:0] prio_reg [4];
    logic [7:0] cc_reg;
    logic [13:0] pending_reg;
    logic [13:0] enable_reg;
    logic nested_reg;
    logic spi_slave_reg;
    logic halt_exit_reg;
    logic [13:0] exit_mask_reg;
    logic [3:0] depth_reg;
    logic take_reg;
    logic take_trap_reg;
    logic [3:0] take_vector_reg;
    logic [15:0] vector_addr_reg;
    logic wake_reg;
    logic br_masked_reg;
    logic br_unmasked_reg;
    logic [31:0] dat_reg;
    logic ack_reg;

    logic [27:0] prio_flat;
    logic [1:0] cur_level;
    logic [13:0] wake_mask;
    logic [13:0] eligible;
    logic found;
    logic [3:0] winner;
    logic [1:0] win_code;
    logic bus_req;
    logic bus_wr;
    logic [5:0] idx;
    logic trap_now;
    logic mask_take;

    // Keeps a pair when the written code is the reserved main-level code.
    function automatic logic [7:0] filter_prio(input logic [7:0] old_v, input logic [7:0] new_v);
        logic [7:0] r;
        r = new_v;
        for (int p = 0; p < 4; p++) begin
            if (new_v[2*p +: 2] == LVL_MAIN) begin
                r[2*p +: 2] = old_v[2*p +: 2];
            end
        end
        return r;
    endfunction

    // Vector x fetches two bytes below vector x-1.
    function automatic logic [15:0] vec_addr(input logic [3:0] v);
        return VEC_BASE_ADDR - {11'd0, v, 1'b0};
    endfunction

    assign prio_flat = {prio_reg[3][3:0], prio_reg[2], prio_reg[1], prio_reg[0]};
    // RULE7 level bits position
    assign cur_level = {cc_reg[LVL_HI_POS], cc_reg[LVL_LO_POS]};
    assign bus_req = cyc_i && stb_i && !ack_reg;
    assign bus_wr = bus_req && we_i && sel_i[0];
    assign idx = adr_i[7:2];
    assign trap_now = instr_valid_i && (instr_op_i == OP_TRAP);

    wake_filter u_wake (
        .pwr_state_i(pwr_state_i),
        .spi_slave_i(spi_slave_reg),
        .wake_mask_o(wake_mask)
    );

    // RULE23 enable and level gate
    // RULE4 concurrent mode blocks preemption
    // RULE2 halt exit restricts competitors
    always_comb begin
        for (int i = 0; i < NUM_VEC; i++) begin
            eligible[i] = pending_reg[i] && enable_reg[i]
                && (level_rank(prio_flat[2*i +: 2]) > level_rank(cur_level))
                && (nested_reg || depth_reg == 4'd0)
                && (!halt_exit_reg || exit_mask_reg[i]);
        end
    end

    prio_arbiter u_arb (
        .eligible_i(eligible),
        .prio_i(prio_flat),
        .found_o(found),
        .winner_o(winner)
    );

    assign win_code = prio_flat[2*winner +: 2];
    // RULE24 entry only at instruction end
    assign mask_take = boundary_i && !instr_valid_i && found;

    // RULE14 priority registers, reset and read-only nibble
    // RULE16 reserved code write ignored per pair
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int r = 0; r < 4; r++) begin
                prio_reg[r] <= PRIO_RESET;
            end
        end else if (bus_wr && idx >= IDX_PRIO0 && idx <= IDX_PRIO3) begin
            // RULE18 new priority applies at next arbitration
            if (idx == IDX_PRIO3) begin
                prio_reg[3] <= filter_prio(prio_reg[3], dat_i[7:0]) | PRIO3_RO_MASK;
            end else begin
                prio_reg[idx[1:0]] <= filter_prio(prio_reg[idx[1:0]], dat_i[7:0]);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            enable_reg <= ENABLE_RESET;
            nested_reg <= 1'b1;
            spi_slave_reg <= 1'b0;
        end else if (bus_wr && idx == IDX_ENABLE) begin
            enable_reg <= dat_i[13:0];
        end else if (bus_wr && idx == IDX_CTRL) begin
            nested_reg <= dat_i[CTRL_NESTED_POS];
            spi_slave_reg <= dat_i[CTRL_SPI_SLAVE_POS];
        end
    end

    // RULE22 unserved requests stay latched; a new request beats the clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pending_reg <= '0;
        end else begin
            pending_reg <= (pending_reg & ~(mask_take ? 14'(1) << winner : 14'd0)) | irq_req_i;
        end
    end

    // RULE3 only the first service after halt is restricted
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            halt_exit_reg <= 1'b0;
            exit_mask_reg <= '0;
        end else if (pwr_state_i == PWR_HALT || pwr_state_i == PWR_ACTIVE_HALT
                     || pwr_state_i == PWR_AWU_HALT) begin
            halt_exit_reg <= 1'b1;
            exit_mask_reg <= wake_mask;
        end else if (mask_take || trap_now) begin
            halt_exit_reg <= 1'b0;
        end
    end

    // RULE6 depth wraps silently
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            depth_reg <= 4'd0;
        end else if (mask_take || trap_now) begin
            depth_reg <= depth_reg + 4'd1;
        end else if (instr_valid_i && instr_op_i == OP_RETURN_FROM_IRQ_INSTR) begin
            depth_reg <= depth_reg - 4'd1;
        end
    end

    // RULE13 level instructions
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            // RULE17 reset leaves level 3
            cc_reg <= COND_RESET;
        end else if (instr_valid_i) begin
            case (instr_op_i)
                // RULE11 instruction level loads
                OP_RIM, OP_HALT, OP_WFI: begin
                    cc_reg[LVL_HI_POS] <= LVL_MAIN[1];
                    cc_reg[LVL_LO_POS] <= LVL_MAIN[0];
                end
                // RULE9 trap accepted at level 3
                OP_SIM, OP_TRAP: begin
                    cc_reg[LVL_HI_POS] <= LVL_DISABLE[1];
                    cc_reg[LVL_LO_POS] <= LVL_DISABLE[0];
                end
                // RULE25 return restores level
                OP_RETURN_FROM_IRQ_INSTR, OP_POPCC: begin
                    cc_reg <= stack_cc_i;
                end
                default: begin
                    cc_reg <= cc_reg;
                end
            endcase
        end else if (mask_take) begin
            // RULE10 load vector priority
            cc_reg[LVL_HI_POS] <= win_code[1];
            cc_reg[LVL_LO_POS] <= win_code[0];
        end
    end

    // RULE15 vector address per number
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            take_reg <= 1'b0;
            take_trap_reg <= 1'b0;
            take_vector_reg <= 4'd0;
            vector_addr_reg <= VEC_RESET_ADDR;
        end else begin
            take_reg <= trap_now || mask_take;
            take_trap_reg <= trap_now;
            if (trap_now) begin
                vector_addr_reg <= VEC_TRAP_ADDR;
            end else if (mask_take) begin
                take_vector_reg <= winner;
                vector_addr_reg <= vec_addr(winner);
            end
        end
    end

    // RULE1 any request wakes from wait
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wake_reg <= 1'b0;
        end else if (pwr_state_i == PWR_WAIT) begin
            wake_reg <= |pending_reg;
        end else if (pwr_state_i == PWR_RUN) begin
            wake_reg <= 1'b0;
        end else begin
            wake_reg <= |(pending_reg & enable_reg & wake_mask);
        end
    end

    // RULE12 branch conditions
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            br_masked_reg <= 1'b1;
            br_unmasked_reg <= 1'b0;
        end else begin
            br_masked_reg <= (cur_level == LVL_DISABLE);
            br_unmasked_reg <= (cur_level != LVL_DISABLE);
        end
    end

    // Unmapped addresses answer with zero and drop writes.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            dat_reg <= '0;
        end else begin
            ack_reg <= bus_req;
            dat_reg <= '0;
            if (bus_req && !we_i) begin
                case (idx)
                    IDX_PRIO0: dat_reg <= {24'd0, prio_reg[0]};
                    IDX_PRIO1: dat_reg <= {24'd0, prio_reg[1]};
                    IDX_PRIO2: dat_reg <= {24'd0, prio_reg[2]};
                    IDX_PRIO3: dat_reg <= {24'd0, prio_reg[3]};
                    IDX_CTRL: dat_reg <= {30'd0, spi_slave_reg, nested_reg};
                    IDX_ENABLE: dat_reg <= {18'd0, enable_reg};
                    IDX_PENDING: dat_reg <= {18'd0, pending_reg};
                    IDX_COND: dat_reg <= {20'd0, depth_reg, cc_reg};
                    default: dat_reg <= '0;
                endcase
            end
        end
    end

    assign dat_o = dat_reg;
    assign ack_o = ack_reg;
    assign take_o = take_reg;
    assign take_trap_o = take_trap_reg;
    assign take_vector_o = take_vector_reg;
    assign vector_addr_o = vector_addr_reg;
    assign cc_o = cc_reg;
    assign wake_o = wake_reg;
    assign branch_masked_o = br_masked_reg;
    assign branch_unmasked_o = br_unmasked_reg;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_trap_issued;
        instr_valid_i && instr_op_i == OP_TRAP;
    endsequence

    sequence s_trap_entered;
        take_o && take_trap_o && cur_level == LVL_DISABLE && vector_addr_o == VEC_TRAP_ADDR;
    endsequence

    a_trap_entry: assert property (s_trap_issued |=> s_trap_entered) // RULE9
        else $error("trap not entered at level 3");

    a_rim_level: assert property (instr_valid_i && instr_op_i == OP_RIM // RULE11
        |=> cur_level == LVL_MAIN ##1 branch_unmasked_o && !branch_masked_o)
        else $error("enable instruction did not load main level");

    a_entry_level: assert property (mask_take |=> take_o // RULE10
        && cur_level == $past(win_code) && !take_trap_o)
        else $error("entry level differs from vector priority");

    a_entry_addr: assert property (mask_take |=> vector_addr_o // RULE15
        == VEC_BASE_ADDR - {11'd0, $past(winner), 1'b0})
        else $error("wrong vector address");

    a_prio_no_main: assert property ((prio_flat[1:0] != LVL_MAIN) // RULE16
        && (prio_flat[27:26] != LVL_MAIN) && (prio_reg[1][7:6] != LVL_MAIN))
        else $error("reserved code stored in a priority pair");

    a_prio3_ones: assert property (prio_reg[3][7:4] == 4'hF) // RULE14
        else $error("read-only nibble of priority register 3 changed");

    a_wait_wake: assert property (pwr_state_i == PWR_WAIT && |pending_reg // RULE1
        |=> wake_o)
        else $error("pending request did not wake from wait");

    a_halt_first: assert property (mask_take && halt_exit_reg // RULE2
        |-> exit_mask_reg[winner])
        else $error("first entry after halt cannot wake");

    a_no_preempt: assert property (!nested_reg && depth_reg != 4'd0 // RULE4
        |=> !take_o || take_trap_o)
        else $error("concurrent mode preempted a routine");

    a_branch_flags: assert property (##1 branch_masked_o == // RULE12
        ($past(cur_level) == LVL_DISABLE) && branch_unmasked_o != branch_masked_o)
        else $error("branch flags disagree with level");

    a_pend_kept: assert property ($past(pending_reg[0]) && !pending_reg[0] // RULE22
        |-> $past(mask_take) && $past(winner) == 4'd0)
        else $error("pending request dropped without service");

endmodule

// *** bench/core_model.sv ***
// Core-side model: instruction ends and the saved condition-code stack.
module core_model (
    input wire logic clk_i, // Core clock.
    input wire logic rst_i, // Synchronous reset.
    input wire logic accept_i, // Core may stop at instruction ends.
    input wire logic take_i, // Entry pulse.
    input wire logic [7:0] cc_i, // Live condition code.
    input wire logic instr_valid_i, // Instruction strobe.
    input wire irq_ctrl_pkg::instr_e instr_op_i, // Executed instruction.
    output logic boundary_o, // At an instruction end.
    output logic [7:0] stack_cc_o // Condition code on top of stack.
);
    timeunit 1ns;
    timeprecision 1ps;
    import irq_ctrl_pkg::*;
    logic [7:0] stack_reg [8];
    logic [2:0] sp_reg;
    logic [7:0] prev_cc_reg;
    assign boundary_o = accept_i;
    assign stack_cc_o = stack_reg[sp_reg - 3'h1];
    always_ff @(posedge clk_i) begin
        prev_cc_reg <= cc_i;
        if (rst_i) begin
            sp_reg <= 3'h0;
            for (int i = 0; i < 8; i++) begin
                stack_reg[i] <= 8'hEA;
            end
        end else if (take_i) begin
            stack_reg[sp_reg] <= prev_cc_reg;
            sp_reg <= sp_reg + 3'h1;
        end else if (instr_valid_i && instr_op_i == OP_RETURN_FROM_IRQ_INSTR) begin
            sp_reg <= sp_reg - 3'h1;
        end
    end
endmodule

// *** bench/tb_nested_irq_ctrl.sv ***
// Self-checking bench for the nested interrupt controller.
module tb_nested_irq_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    import irq_ctrl_pkg::*;
    typedef struct packed {logic w; logic [7:0] a; logic [7:0] d; logic [31:0] e;} row_s;
    logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic instr_valid = 1'b0, accept = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h1;
    logic [31:0] wdat = 32'h0000_0000, rdat, dat_r;
    logic [13:0] irq = 14'h0000;
    instr_e op = OP_NONE;
    pwr_e pwr = PWR_RUN;
    logic ack, take, take_trap, wake, bm, bu, boundary;
    logic [3:0] take_vec;
    logic [15:0] vaddr;
    logic [7:0] cc, stack_cc;
    int err_count = 0, comparisons = 0;
    row_s rows [12] = '{
        '{1'b0, 8'h90, 8'h00, 32'h0000_00FF}, '{1'b0, 8'h9C, 8'h00, 32'h0000_00FF},
        '{1'b0, 8'h8C, 8'h00, 32'h0000_00EA}, '{1'b0, 8'h84, 8'h00, 32'h0000_3FFF},
        '{1'b0, 8'h80, 8'h00, 32'h0000_0001}, '{1'b0, 8'h88, 8'h00, 32'h0000_0000},
        '{1'b0, 8'h00, 8'h00, 32'h0000_0000}, '{1'b1, 8'h90, 8'hCF, 32'h0000_00CF},
        '{1'b1, 8'h90, 8'h64, 32'h0000_0044}, '{1'b1, 8'h9C, 8'h00, 32'h0000_00F0},
        '{1'b1, 8'h94, 8'hAA, 32'h0000_00FF}, '{1'b1, 8'h88, 8'hFF, 32'h0000_0000}};
    instr_e ops [6] = '{OP_SIM, OP_HALT, OP_SIM, OP_WFI, OP_POPCC, OP_RIM};
    logic [1:0] codes [6] = '{LVL_DISABLE, LVL_MAIN, LVL_DISABLE, LVL_MAIN, LVL_DISABLE, LVL_MAIN};
    pwr_e hs [4] = '{PWR_WAIT, PWR_HALT, PWR_ACTIVE_HALT, PWR_AWU_HALT};

    nested_irq_ctrl nested_irq_ctrl_inst (
        .clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .sel_i(sel), .dat_i(wdat), .dat_o(dat_r), .ack_o(ack), .irq_req_i(irq),
        .instr_valid_i(instr_valid), .instr_op_i(op), .stack_cc_i(stack_cc),
        .boundary_i(boundary), .pwr_state_i(pwr), .take_o(take), .take_trap_o(take_trap),
        .take_vector_o(take_vec), .vector_addr_o(vaddr), .cc_o(cc), .wake_o(wake),
        .branch_masked_o(bm), .branch_unmasked_o(bu));
    core_model core_model_inst (
        .clk_i(clk), .rst_i(rst), .accept_i(accept), .take_i(take), .cc_i(cc),
        .instr_valid_i(instr_valid), .instr_op_i(op), .boundary_o(boundary),
        .stack_cc_o(stack_cc));

    initial begin
        forever #2 clk = ~clk;
    end

    function automatic logic [1:0] lvl();
        lvl = {cc[LVL_HI_POS], cc[LVL_LO_POS]};
    endfunction

    function automatic logic [13:0] wmask(input pwr_e s, input logic spi);
        wmask = 14'h003C | {5'h00, spi, 8'h00};
        if (s == PWR_ACTIVE_HALT) wmask[1] = 1'b1;
        if (s == PWR_AWU_HALT) wmask[0] = 1'b1;
        if (s == PWR_WAIT) wmask = 14'h3FFF;
    endfunction

    task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic summarize();
        if (err_count == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic do_reset();
        rst <= 1'b1;
        pwr <= PWR_RUN;
        accept <= 1'b0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h00_0000, d};
        @(posedge clk);
        while (ack !== 1'b1) @(posedge clk);
        rdat = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask

    task automatic run(input instr_e o);
        instr_valid <= 1'b1;
        op <= o;
        @(posedge clk);
        instr_valid <= 1'b0;
        @(posedge clk);
    endtask

    task automatic take_wait(input logic [3:0] v, input logic [1:0] l);
        int n;
        n = 0;
        while (take !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        check("take_o", 1, take);
        check("take_vector_o", v, take_vec);
        check("vector_addr_o", 16'hFFFA - {11'h000, v, 1'b0}, vaddr);
        check("level", l, lvl());
        @(posedge clk);
    endtask

    initial begin
        logic [13:0] m;
        do_reset();
        foreach (rows[i]) begin
            if (rows[i].w) wb(1'b1, rows[i].a, rows[i].d);
            wb(1'b0, rows[i].a, 8'h00);
            check("register", rows[i].e, rdat);
        end
        run(OP_TRAP);
        check("take_o", 1, take);
        check("take_trap_o", 1, take_trap);
        check("vector_addr_o", 16'hFFFC, vaddr);
        check("level", LVL_DISABLE, lvl());
        foreach (ops[i]) begin
            run(ops[i]);
            check("level", codes[i], lvl());
            @(posedge clk);
            check("branch_masked_o", codes[i] == LVL_DISABLE, bm);
            check("branch_unmasked_o", codes[i] != LVL_DISABLE, bu);
        end
        wb(1'b1, 8'h90, 8'h1F);
        irq <= 14'h000C;
        @(posedge clk);
        irq <= 14'h0000;
        accept <= 1'b1;
        take_wait(4'h3, LVL_TWO);
        repeat (6) @(posedge clk);
        wb(1'b0, 8'h88, 8'h00);
        check("pending", 32'h0000_0004, rdat);
        run(OP_RETURN_FROM_IRQ_INSTR);
        check("level", LVL_MAIN, lvl());
        take_wait(4'h2, LVL_ONE);
        wb(1'b1, 8'h80, 8'h00);
        irq <= 14'h0008;
        @(posedge clk);
        irq <= 14'h0000;
        repeat (6) @(posedge clk);
        wb(1'b0, 8'h88, 8'h00);
        check("pending", 32'h0000_0008, rdat);
        wb(1'b1, 8'h80, 8'h01);
        take_wait(4'h3, LVL_TWO);
        foreach (hs[s]) begin
            for (int k = 0; k < 28; k++) begin
                do_reset();
                wb(1'b1, 8'h80, {6'h00, k[0], 1'b1});
                irq <= 14'h0001 << (k / 2);
                pwr <= hs[s];
                @(posedge clk);
                irq <= 14'h0000;
                repeat (3) @(posedge clk);
                m = wmask(hs[s], k[0]);
                check("wake_o", m[k / 2], wake);
            end
        end
        do_reset();
        irq <= 14'h3FFF;
        pwr <= PWR_HALT;
        repeat (3) @(posedge clk);
        irq <= 14'h0000;
        pwr <= PWR_RUN;
        run(OP_RIM);
        accept <= 1'b1;
        take_wait(4'h2, LVL_DISABLE);
        run(OP_RETURN_FROM_IRQ_INSTR);
        take_wait(4'h0, LVL_DISABLE);
        run(OP_POPCC);
        check("level", LVL_MAIN, lvl());
        summarize();
    end

    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        summarize();
    end
endmodule
